// [src/radio_power_mode_controller.sv]
/*
  Power-mode controller of a serial radio module: mode sequencing, RF wake-up,
  monitor listen windows, flow control, sensor line setup, APB register file.
  Assumes an APB3 master on clk_i; pins arrive asynchronously and are synchronised.
*/
`timescale 1ns/1ps
`include "rpm_consts.svh"
module radio_power_mode_controller #(
  parameter int unsigned WAKE_CYC     = `RF_WAKE_CYC,
  parameter int unsigned LISTEN_CYC   = `LISTEN_CYC,
  parameter int unsigned MON_BASE_CYC = `MON_BASE_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                reset_pin_i,
  input  wire logic [`ADDR_W-1:0]  paddr_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  input  wire logic                txd_i,
  input  wire logic                rts_i,
  output logic                     cts_o,
  output logic      [`FIFO_W-1:0]  rx_byte_o,
  output logic                     rx_valid_o,
  input  wire logic                carrier_i,
  output logic                     core_power_o,
  output logic                     rf_power_o,
  output logic                     rx_enable_o,
  output logic                     tx_enable_o,
  input  wire logic [3:0]          sensor_io_line_i,
  output logic      [3:0]          sensor_io_line_o,
  output logic      [3:0]          sensor_io_line_oe_o,
  input  wire logic                analog_input_0_i,
  input  wire logic                analog_input_1_i,
  input  wire logic [`ADC_W-1:0]   analog_input_0_code_i,
  input  wire logic [`ADC_W-1:0]   analog_input_1_code_i
);
  localparam int LW = $clog2(`FIFO_DEPTH) + 1;
  localparam int SW = 10;

  logic [SW-1:0]         sync1_r;
  logic [SW-1:0]         sync2_r;
  logic                  txd_prev_r;
  logic                  rst;
  rpm_pkg::pwr_state_type state_r;
  rpm_pkg::pwr_state_type resume_r;
  rpm_pkg::pmode_type    mode_r;
  logic [31:0]           cnt_r;
  logic                  tx_dir_r;
  logic [9:0]            sensor_r;
  logic [31:0]           prdata_r;
  logic [31:0]           rdata_nxt;
  logic                  pready_r;
  logic                  pslverr_r;
  logic                  cts_r;
  logic                  core_pwr_r;
  logic                  rf_pwr_r;
  logic                  rx_en_r;
  logic                  tx_en_r;
  logic [`FIFO_W-1:0]    rx_byte_r;
  logic                  rx_valid_r;
  logic                  fin;
  logic                  wr;
  logic                  mode_wr;
  logic                  rf_wr;
  logic                  rf_go;
  logic                  rf_end;
  rpm_pkg::pmode_type    new_mode;
  logic                  txd_s;
  logic                  rts_s;
  logic                  carrier_s;
  logic                  txd_act;
  logic [3:0]            dio_s;
  logic [1:0]            ana_s;

  fifo_if #(.W(`FIFO_W), .LW(LW)) fq ();

  data_fifo #(.W(`FIFO_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk_i (clk_i),
    .rst_i (rst),
    .q     (fq)
  );

  // selected power mode to its resting state
  function automatic rpm_pkg::pwr_state_type base_state(input rpm_pkg::pmode_type m);
    case (m)
      `PM_IDLE:  base_state = rpm_pkg::S_IDLE;
      `PM_SLEEP: base_state = rpm_pkg::S_SLEEP;
      `PM_PDOWN: base_state = rpm_pkg::S_PDOWN;
      default:   base_state = rpm_pkg::S_MON_WAIT;
    endcase
  endfunction : base_state

  // monitor sleep interval, doubling per code step
  function automatic logic [31:0] load_cnt(input rpm_pkg::pmode_type m);
    if (m >= `PM_MON_FIRST) begin
      load_cnt = (MON_BASE_CYC << (m - `PM_MON_FIRST)) - 32'h1;
    end else begin
      load_cnt = 32'h0;
    end
  endfunction : load_cnt

  // address decode, used for the error response only
  function automatic logic mapped(input logic [`ADDR_W-1:0] a);
    mapped = (a == `OFS_MODE) || (a == `OFS_RFCMD) || (a == `OFS_STATUS) ||
             (a == `OFS_SENSOR) || (a == `OFS_ANALOG) || (a == `OFS_DATA);
  endfunction : mapped

  // two-stage synchroniser for every pin input
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync1_r <= `SYNC_IDLE;  // txd rests high so no false wake edge follows reset
      sync2_r <= `SYNC_IDLE;
    end else begin
      sync1_r <= {analog_input_1_i, analog_input_0_i, sensor_io_line_i,
                  carrier_i, rts_i, txd_i, reset_pin_i};
      sync2_r <= sync1_r;
    end
  end

  assign rst       = !rst_b_i | sync2_r[0];
  assign txd_s     = sync2_r[1];
  assign rts_s     = sync2_r[2];
  assign carrier_s = sync2_r[3];
  assign dio_s     = sync2_r[7:4];
  assign ana_s     = sync2_r[9:8];

  // txd edge detect for wake-up
  always_ff @(posedge clk_i) begin
    if (rst) begin
      txd_prev_r <= 1'b1;
    end else begin
      txd_prev_r <= txd_s;
    end
  end
  assign txd_act = (txd_s != txd_prev_r);

  // bus strobes; sleep drops commands
  assign fin      = psel_i & penable_i & pready_r;
  assign wr       = fin & pwrite_i;
  assign mode_wr  = wr && (paddr_i == `OFS_MODE) && (state_r != rpm_pkg::S_SLEEP);
  assign rf_wr    = wr && (paddr_i == `OFS_RFCMD) && (state_r != rpm_pkg::S_SLEEP);
  assign rf_go    = rf_wr & (pwdata_i[`RF_TX_BIT] | pwdata_i[`RF_RX_BIT]);
  assign rf_end   = rf_wr & pwdata_i[`RF_END_BIT];
  assign new_mode = pwdata_i[`MODE_NOPARAM] ? `PM_IDLE : pwdata_i[2:0];
  assign fq.wdata  = pwdata_i[`FIFO_W-1:0];
  assign fq.wvalid = wr && (paddr_i == `OFS_DATA);
  assign fq.rready = !rts_s && (state_r != rpm_pkg::S_SLEEP);

  // apb answer: ready one cycle into access, data writes held off while fifo full
  always_ff @(posedge clk_i) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r <= psel_i & penable_i & !pready_r &
                  !(pwrite_i && (paddr_i == `OFS_DATA) && !fq.wready);
      if (psel_i & penable_i & !pready_r) begin
        pslverr_r <= !mapped(paddr_i);
        prdata_r  <= rdata_nxt;
      end
    end
  end

  // read mux
  always_comb begin
    rdata_nxt = 32'h0;
    case (paddr_i)
      `OFS_MODE:   rdata_nxt = {29'h0, mode_r};
      `OFS_STATUS: rdata_nxt = {16'h0, 3'h0, LW'(fq.level), rx_en_r, tx_en_r, rf_pwr_r,
                                cts_r, 1'b0, state_r};
      `OFS_SENSOR: rdata_nxt = {16'h0, ana_s, dio_s, sensor_r};
      `OFS_ANALOG: begin
        rdata_nxt[`ADC_W-1:0]     = sensor_r[8] ? `ADC_W'(ana_s[0]) : analog_input_0_code_i;
        rdata_nxt[16+`ADC_W-1:16] = sensor_r[9] ? `ADC_W'(ana_s[1]) : analog_input_1_code_i;
      end
      default:     rdata_nxt = 32'h0;
    endcase
  end

  // stored power mode, codes above the last are ignored
  always_ff @(posedge clk_i) begin
    if (rst) begin
      mode_r <= `PM_IDLE;
    end else if (mode_wr && (new_mode <= `PM_MAX)) begin
      mode_r <= new_mode;
    end
  end

  // sensor setup: [3:0] drive enable, [7:4] level, [9:8] analog as digital
  always_ff @(posedge clk_i) begin
    if (rst) begin
      sensor_r <= '0;
    end else if (wr && (paddr_i == `OFS_SENSOR)) begin
      sensor_r <= pwdata_i[9:0];
    end
  end

  // power state sequencer
  always_ff @(posedge clk_i) begin
    if (rst) begin
      state_r  <= rpm_pkg::S_IDLE;
      resume_r <= rpm_pkg::S_IDLE;
      cnt_r    <= '0;
      tx_dir_r <= 1'b0;
    end else if (mode_wr && (new_mode <= `PM_MAX) && (state_r != rpm_pkg::S_WARMUP) &&
                 (state_r != rpm_pkg::S_ACTIVE)) begin
      state_r <= base_state(new_mode);
      cnt_r   <= load_cnt(new_mode);
      if (new_mode == `PM_SLEEP) begin
        resume_r <= (state_r == rpm_pkg::S_IDLE) ? rpm_pkg::S_IDLE : rpm_pkg::S_PDOWN;
      end
    end else if (rf_go && (state_r != rpm_pkg::S_WARMUP) && (state_r != rpm_pkg::S_ACTIVE)) begin
      tx_dir_r <= pwdata_i[`RF_TX_BIT];
      if (state_r == rpm_pkg::S_PDOWN || state_r == rpm_pkg::S_MON_WAIT) begin
        state_r <= rpm_pkg::S_WARMUP;
        cnt_r   <= WAKE_CYC - 32'h1;
      end else begin
        state_r <= rpm_pkg::S_ACTIVE;
      end
    end else begin
      case (state_r)
        rpm_pkg::S_SLEEP: begin
          if (txd_act) state_r <= resume_r;
        end
        rpm_pkg::S_WARMUP: begin
          if (cnt_r == 32'h0) state_r <= rpm_pkg::S_ACTIVE;
          else cnt_r <= cnt_r - 32'h1;
        end
        rpm_pkg::S_ACTIVE: begin
          if (rf_end) begin
            state_r <= base_state(mode_r);
            cnt_r   <= load_cnt(mode_r);
          end
        end
        rpm_pkg::S_MON_WAIT: begin
          if (cnt_r == 32'h0) begin
            state_r <= rpm_pkg::S_MON_LISTEN;
            cnt_r   <= LISTEN_CYC - 32'h1;
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        rpm_pkg::S_MON_LISTEN: begin
          if (carrier_s) begin
            state_r <= rpm_pkg::S_MON_RX;
          end else if (cnt_r == 32'h0) begin
            state_r <= rpm_pkg::S_MON_WAIT;
            cnt_r   <= load_cnt(mode_r);
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        rpm_pkg::S_MON_RX: begin
          if (!carrier_s) begin
            state_r <= rpm_pkg::S_MON_WAIT;
            cnt_r   <= load_cnt(mode_r);
          end
        end
        default: state_r <= state_r;
      endcase
    end
  end

  // power and enable outputs follow the state one cycle later
  always_ff @(posedge clk_i) begin
    if (rst) begin
      core_pwr_r <= 1'b1;
      rf_pwr_r   <= 1'b1;
      rx_en_r    <= 1'b1;
      tx_en_r    <= 1'b0;
      cts_r      <= 1'b0;
    end else begin
      core_pwr_r <= (state_r != rpm_pkg::S_SLEEP);
      rf_pwr_r   <= !(state_r inside {rpm_pkg::S_SLEEP, rpm_pkg::S_PDOWN,
                                      rpm_pkg::S_MON_WAIT});
      rx_en_r    <= (state_r inside {rpm_pkg::S_IDLE, rpm_pkg::S_MON_LISTEN,
                                     rpm_pkg::S_MON_RX}) ||
                    (state_r == rpm_pkg::S_ACTIVE && !tx_dir_r);
      tx_en_r    <= (state_r == rpm_pkg::S_ACTIVE) && tx_dir_r;
      cts_r      <= (state_r == rpm_pkg::S_WARMUP);
    end
  end

  // receive byte stream toward the host
  always_ff @(posedge clk_i) begin
    if (rst) begin
      rx_valid_r <= 1'b0;
      rx_byte_r  <= '0;
    end else begin
      rx_valid_r <= fq.rvalid & fq.rready;
      if (fq.rvalid & fq.rready) rx_byte_r <= fq.rdata;
    end
  end

  assign prdata_o            = prdata_r;
  assign pready_o            = pready_r;
  assign pslverr_o           = pslverr_r;
  assign cts_o               = cts_r;
  assign rx_byte_o           = rx_byte_r;
  assign rx_valid_o          = rx_valid_r;
  assign core_power_o        = core_pwr_r;
  assign rf_power_o          = rf_pwr_r;
  assign rx_enable_o         = rx_en_r;
  assign tx_enable_o         = tx_en_r;
  assign sensor_io_line_oe_o = sensor_r[3:0];
  assign sensor_io_line_o    = sensor_r[7:4];

  // helper: length of the current wake-up
  logic [31:0] warm_len_r;
  always_ff @(posedge clk_i) begin
    if (rst || state_r != rpm_pkg::S_WARMUP) warm_len_r <= '0;
    else warm_len_r <= warm_len_r + 32'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst);

  a_sleep_drops_mode: assert property (
    state_r == rpm_pkg::S_SLEEP && wr && paddr_i == `OFS_MODE |=> $stable(mode_r))
    else $error("mode changed during sleep");
  a_idle_rx_on: assert property (
    state_r == rpm_pkg::S_IDLE ##1 state_r == rpm_pkg::S_IDLE |-> rx_en_r && rf_pwr_r)
    else $error("idle without receiver");
  a_pdown_rf_off: assert property (
    state_r == rpm_pkg::S_PDOWN |=> !rf_pwr_r && !rx_en_r)
    else $error("rf powered in power-down");
  a_wake_bound: assert property (
    state_r == rpm_pkg::S_WARMUP |-> warm_len_r < WAKE_CYC)
    else $error("rf wake-up too long");
  a_sleep_wake_back: assert property (
    state_r == rpm_pkg::S_SLEEP && txd_act |=> state_r == $past(resume_r))
    else $error("sleep wake went to wrong state");
  a_listen_timeout: assert property (
    state_r == rpm_pkg::S_MON_LISTEN && cnt_r == 32'h0 && !carrier_s && !mode_wr && !rf_go
    |=> state_r == rpm_pkg::S_MON_WAIT)
    else $error("listen window not closed");
  a_carrier_hold: assert property (
    state_r == rpm_pkg::S_MON_RX && carrier_s && !mode_wr && !rf_go
    |=> state_r == rpm_pkg::S_MON_RX)
    else $error("carrier transaction cut short");
  a_rts_holds_rx: assert property (
    rts_s |=> !rx_valid_r)
    else $error("receive byte sent while paused");
  a_noparam_idle: assert property (
    mode_wr && pwdata_i[`MODE_NOPARAM] |=> mode_r == `PM_IDLE)
    else $error("missing parameter not idle");
  a_cts_in_warmup: assert property (
    state_r == rpm_pkg::S_WARMUP |=> cts_r)
    else $error("clear-to-send low in wake-up");
  a_rf_end_return: assert property (
    state_r == rpm_pkg::S_ACTIVE && rf_end |=> state_r == base_state($past(mode_r)))
    else $error("no return after rf operation");

  c_sleep_wake: cover property (state_r == rpm_pkg::S_SLEEP ##1 state_r != rpm_pkg::S_SLEEP);
  c_mon_carrier: cover property (state_r == rpm_pkg::S_MON_RX);
  c_warm_done: cover property (state_r == rpm_pkg::S_WARMUP ##1 state_r == rpm_pkg::S_ACTIVE);
endmodule : radio_power_mode_controller

// [src/rpm_consts.svh]
/*
  Address map, field positions, mode codes and timing figures of the power-mode block.
  Assumes a 200 MHz clock and 32-bit APB data with word-aligned registers.
*/
// Function
// - idle behaviour follows last power mode command
// - idle keeps everything powered, receiver listening
// - sleep powers down, ignores commands and RF
// - serial input activity wakes to prior mode (monitor modes wake to power-down)
// - power-down: RF off, commands still accepted
// - RF wake-up from power-down under 200 us
// - monitor: wait interval, listen, repeat
// - silent listen window ends after 200 ms
// - carrier keeps listening until transaction ends
// - codes 0,1,2 select idle, sleep, power-down
// - codes 3..6 select 2,4,8,16 s monitor
// - clear-to-send high pauses host data
// - request-to-send high holds back receive data
// - high reset pin resets, open pin harmless
// - four sensor lines, each input or output
// - analog inputs: 12-bit code or digital
// - missing parameter counts as zero
`ifndef RPM_CONSTS_SVH
`define RPM_CONSTS_SVH
`define ADDR_W        12
`define OFS_MODE      12'h000
`define OFS_RFCMD     12'h004
`define OFS_STATUS    12'h008
`define OFS_SENSOR    12'h00C
`define OFS_ANALOG    12'h010
`define OFS_DATA      12'h014
`define PM_IDLE       3'h0
`define PM_SLEEP      3'h1
`define PM_PDOWN      3'h2
`define PM_MON_FIRST  3'h3
`define PM_MAX        3'h6
`define MODE_NOPARAM  3
`define RF_TX_BIT     0
`define RF_RX_BIT     1
`define RF_END_BIT    2
`define CLK_MHZ       200
`define RF_WAKE_US    200
`define LISTEN_MS     200
`define MON_BASE_S    2
`define RF_WAKE_CYC   ((`RF_WAKE_US * `CLK_MHZ) - 1)
`define LISTEN_CYC    (`LISTEN_MS * 1000 * `CLK_MHZ)
`define MON_BASE_CYC  (`MON_BASE_S * 1000000 * `CLK_MHZ)
`define FIFO_W        8
`define FIFO_DEPTH    16
`define ADC_W         12
`define SYNC_IDLE     10'h002  // synchroniser rest levels: txd idles high, rest low
`endif

// [src/rpm_pkg.sv]
/*
  Types shared by the power-mode block.
  Assumes nothing of its surroundings.
*/
package rpm_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_SLEEP, S_PDOWN, S_MON_WAIT, S_MON_LISTEN, S_MON_RX, S_WARMUP, S_ACTIVE
  } pwr_state_type;
  typedef logic [2:0] pmode_type;
endpackage : rpm_pkg

// [src/fifo_if.sv]
/*
  Valid/ready carrier between the controller and its byte FIFO.
  Assumes both ends run on one clock.
*/
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 8, parameter int LW = 5);
  logic [W-1:0]  wdata;
  logic          wvalid;
  logic          wready;
  logic [W-1:0]  rdata;
  logic          rvalid;
  logic          rready;
  logic [LW-1:0] level;
  modport store (input wdata, wvalid, rready, output wready, rdata, rvalid, level);
  modport user  (output wdata, wvalid, rready, input wready, rdata, rvalid, level);
endinterface : fifo_if

// [src/data_fifo.sv]
/*
  Synchronous FIFO, width and depth as parameters.
  Assumes a synchronous active-high reset and a power-of-two depth.
*/
`timescale 1ns/1ps
module data_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  fifo_if.store    q
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  // honest flags from the fill count
  assign q.wready = (cnt_r != (AW+1)'(DEPTH));
  assign q.rvalid = (cnt_r != '0);
  assign q.rdata  = mem[rp_r];
  assign q.level  = cnt_r;
  assign push     = q.wvalid & q.wready;
  assign pop      = q.rvalid & q.rready;

  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= q.wdata;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : data_fifo

// [verif/serial_host_model.sv]
/*
  Host side of the serial port: idle-high txd, rts pause, collects received bytes.
  Assumes the bench raises its requests just after a rising edge of clk_i.
*/
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic       clk_i,
  input  wire logic       cts_i,
  input  wire logic [7:0] rx_byte_i,
  input  wire logic       rx_valid_i,
  input  wire logic       pause_i,
  input  wire logic       poke_i,
  output logic            txd_o,
  output logic            rts_o
);
  logic [7:0] got_q[$];
  initial begin
    txd_o = 1'b1;
    rts_o = 1'b0;
  end
  // rts high holds back the device's byte stream
  always @(posedge clk_i) begin
    rts_o <= pause_i;
  end
  // one low bit on txd as line activity, never while the device says pause
  always @(posedge clk_i) begin
    txd_o <= !(poke_i && cts_i !== 1'b1);
  end
  // every byte handed over is kept in arrival order
  always @(posedge clk_i) begin
    if (rx_valid_i === 1'b1) begin
      got_q.push_back(rx_byte_i);
    end
  end
endmodule : serial_host_model

// [verif/radio_power_mode_controller_test.sv]
/*
  Self-checking bench of the power-mode controller: APB master, host model, pins.
  Assumes the design sources and rpm_consts.svh are compiled first.
*/
`timescale 1ns/1ps
`include "rpm_consts.svh"
module radio_power_mode_controller_test;
  logic        clk = 0, rst_b = 0, reset_pin = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic        pready, pslverr, rerr, txd, rts, cts, rx_valid, carrier = 0, pause = 0, poke = 0;
  logic [7:0]  rx_byte;
  logic        core_power, rf_power, rx_enable, tx_enable, ain0 = 0, ain1 = 0;
  logic [3:0]  sio_in, sio_out, sio_oe, sio_ext = '0;
  logic [11:0] ain0_code = '0, ain1_code = '0;
  int          errors = 0, check_count = 0, n;
  // pin level: design where it drives, outside world elsewhere
  assign sio_in = (sio_oe & sio_out) | (~sio_oe & sio_ext);
  initial begin
    forever #2.5 clk = ~clk;
  end
  radio_power_mode_controller #(.WAKE_CYC(8), .LISTEN_CYC(20), .MON_BASE_CYC(30)) u_dut (
    .clk_i(clk), .rst_b_i(rst_b), .reset_pin_i(reset_pin), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .txd_i(txd), .rts_i(rts), .cts_o(cts),
    .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .carrier_i(carrier),
    .core_power_o(core_power), .rf_power_o(rf_power), .rx_enable_o(rx_enable),
    .tx_enable_o(tx_enable), .sensor_io_line_i(sio_in), .sensor_io_line_o(sio_out),
    .sensor_io_line_oe_o(sio_oe), .analog_input_0_i(ain0), .analog_input_1_i(ain1),
    .analog_input_0_code_i(ain0_code), .analog_input_1_code_i(ain1_code));
  serial_host_model u_host (.clk_i(clk), .cts_i(cts), .rx_byte_i(rx_byte),
    .rx_valid_i(rx_valid), .pause_i(pause), .poke_i(poke), .txd_o(txd), .rts_o(rts));

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic give_up(input string m);
    errors++;
    $display("MISMATCH t=%0t timeout %s", $time, m);
    end_of_test();
  endtask : give_up

  // one APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) give_up("pready");
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // count edges until the chosen output reaches the level
  task automatic wsig(input int s, input logic lvl, input int lim, output int c);
    logic v;
    c = 0;
    do begin
      @(posedge clk);
      c++;
      case (s)
        0: v = tx_enable;
        1: v = rx_enable;
        default: v = core_power;
      endcase
    end while (v !== lvl && c < lim);
    if (v !== lvl) give_up("output level");
  endtask : wsig

  task automatic state_is(input logic [2:0] s);
    repeat (3) @(posedge clk);
    apb(0, `OFS_STATUS, 0);
    chk(rdat[2:0], s, "state");
  endtask : state_is

  task automatic t_reset;
    chk({core_power, rf_power, rx_enable, tx_enable, cts}, 5'b11100, "reset pins");
    apb(0, `OFS_MODE, 0);
    chk(rdat[2:0], 0, "reset mode");
    apb(0, 12'h018, 0);
    chk(rerr, 1, "unmapped");
    apb(1, `OFS_MODE, 2);
    reset_pin <= 1'b1;
    repeat (4) @(posedge clk);
    reset_pin <= 1'b0;
    repeat (4) @(posedge clk);
    apb(0, `OFS_MODE, 0);
    chk({rdat[2:0], rf_power}, 4'h1, "pin reset");
  endtask : t_reset

  task automatic t_modes;
    for (int c = 0; c <= 2; c += 2) begin
      apb(1, `OFS_MODE, c);
      state_is(c[2:0]);
      chk({rf_power, rx_enable, core_power}, {c == 0, c == 0, 1'b1}, "rf power");
    end
    apb(1, `OFS_MODE, 7);
    apb(0, `OFS_MODE, 0);
    chk(rdat[2:0], `PM_PDOWN, "bad code");
    apb(1, `OFS_MODE, 32'hD);
    apb(0, `OFS_MODE, 0);
    chk(rdat[2:0], `PM_IDLE, "no param");
  endtask : t_modes

  task automatic t_sleep;
    for (int p = 0; p <= 2; p += 2) begin
      apb(1, `OFS_MODE, p);
      apb(1, `OFS_MODE, `PM_SLEEP);
      state_is(`PM_SLEEP);
      chk({core_power, rf_power}, 0, "sleep power");
      apb(1, `OFS_MODE, `PM_PDOWN);
      apb(0, `OFS_MODE, 0);
      chk(rdat[2:0], `PM_SLEEP, "sleep ignores");
      poke <= 1'b1;
      @(posedge clk);
      poke <= 1'b0;
      wsig(2, 1, 20, n);
      state_is(p[2:0]);
    end
  endtask : t_sleep

  task automatic t_rf;
    for (int k = 0; k < 2; k++) begin
      apb(1, `OFS_MODE, `PM_PDOWN);
      repeat (3) @(posedge clk);
      chk({rf_power, rx_enable, tx_enable}, 0, "pdown rf");
      apb(1, `OFS_RFCMD, 1 << k);
      @(posedge clk);
      chk(cts, 1, "cts pause");
      wsig(k, 1, 20, n);
      chk(n <= 11, 1, "wake time");
      chk({rf_power, cts}, 2'b10, "awake");
      if (k == 1) apb(1, `OFS_MODE, `PM_IDLE);
      apb(1, `OFS_RFCMD, 4);
      state_is(k ? `PM_IDLE : `PM_PDOWN);
    end
  endtask : t_rf

  task automatic t_flow;
    pause <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 16; i++) apb(1, `OFS_DATA, 8'hA0 + i);
    apb(0, `OFS_STATUS, 0);
    chk(rdat[12:8], 16, "fifo full");
    repeat (10) @(posedge clk);
    chk(u_host.got_q.size(), 0, "held back");
    pause <= 1'b0;
    repeat (40) @(posedge clk);
    chk(u_host.got_q.size(), 16, "drained");
    for (int i = 0; i < 16 && u_host.got_q.size() > 0; i++)
      chk(u_host.got_q.pop_front(), 8'hA0 + i, "byte order");
  endtask : t_flow

  task automatic t_sensor;
    sio_ext <= 4'h9;
    ain0 <= 1'b1;
    ain0_code <= 12'hABC;
    ain1_code <= 12'h123;
    apb(1, `OFS_SENSOR, 32'hA5);
    chk({sio_oe, sio_out}, 8'h5A, "line setup");
    repeat (4) @(posedge clk);
    apb(0, `OFS_SENSOR, 0);
    chk(rdat[15:10], 6'h18, "line levels");
    apb(0, `OFS_ANALOG, 0);
    chk({rdat[27:16], rdat[11:0]}, 24'h123ABC, "codes");
    apb(1, `OFS_SENSOR, 32'h100);
    apb(0, `OFS_ANALOG, 0);
    chk({rdat[27:16], rdat[11:0]}, 24'h123001, "analog as digital");
  endtask : t_sensor

  task automatic t_monitor;
    for (int c = 3; c <= 6; c++) begin
      apb(1, `OFS_MODE, `PM_PDOWN);
      apb(1, `OFS_MODE, c);
      wsig(1, 1, 300, n);
      chk(n >= (30 << (c - 3)) - 4 && n <= (30 << (c - 3)) + 4, 1, "interval");
      wsig(1, 0, 40, n);
      chk(n >= 17 && n <= 23, 1, "listen");
    end
    wsig(1, 1, 300, n);
    carrier <= 1'b1;
    repeat (60) @(posedge clk);
    chk(rx_enable, 1, "carrier holds");
    carrier <= 1'b0;
    wsig(1, 0, 30, n);
  endtask : t_monitor

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_modes();
    t_sleep();
    t_rf();
    t_flow();
    t_sensor();
    t_monitor();
    end_of_test();
  end
endmodule : radio_power_mode_controller_test
